//--- common/spicb_pkg.sv
package spicb_pkg;

   // ***************************************************************
   // Register map (plain port, byte offsets)
   // ***************************************************************
   localparam logic [2:0] OFF_CTRL_FIRST = 3'h0;
   localparam logic [2:0] OFF_CTRL_SECOND = 3'h1;
   localparam logic [2:0] OFF_IRQ_ENABLE = 3'h2;
   localparam logic [2:0] OFF_IRQ_FLAG = 3'h3;
   localparam logic [2:0] OFF_DATA = 3'h4;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CF_ENABLE_BIT = 0;
   localparam int CF_BIT_ORDER_BIT = 6;
   localparam int CS_MODE_LSB = 0;
   localparam int CS_WAIT_RECV_BIT = 6;
   localparam int CS_BUF_EN_BIT = 7;
   localparam int FL_OVERFLOW_BIT = 0;
   localparam int FL_SELECT_BIT = 4;
   localparam int FL_EMPTY_BIT = 5;
   localparam int FL_XFER_BIT = 6;
   localparam int FL_RECV_BIT = 7;
   localparam int IE_NORMAL_BIT = 0;

   // ***************************************************************
   // Reset values and counts
   // ***************************************************************
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam logic [7:0] FLAG_RESET = 8'h20;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   localparam int EV_MIN_CYC = 2;
   localparam logic EV_HOLD_CNT = 1'(EV_MIN_CYC - 1);

   // Pin index inside the sync vectors
   localparam int PIN_SCK = 0;
   localparam int PIN_SEL = 1;
   localparam int PIN_MOSI = 2;

   typedef enum logic [1:0] {
      SPICB_IDLE = 2'b01,
      SPICB_SHIFT = 2'b10
   } spicb_state_t;

   // Register bus request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } spicb_req_t;

   // Whole module state
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] filt;
      spicb_state_t st;
      logic [2:0] bitcnt;
      logic pend;
      logic [7:0] tx_sh;
      logic [7:0] rx_sh;
      logic [7:0] txbuf;
      logic txbuf_full;
      logic sh_user;
      logic [7:0] fifo0;
      logic [7:0] fifo1;
      logic [1:0] fcnt;
      logic [7:0] ctrl_first_reg;
      logic [7:0] ctrl_second_reg;
      logic [7:0] irq_enable_reg;
      logic [7:0] irq_flag_reg;
      logic done_d1;
      logic done_d2;
      logic txc_ok;
      logic ev;
      logic ev_cnt;
      logic [7:0] rdata;
      logic miso;
      logic miso_oe;
      logic irq;
   } spicb_regs_t;

endpackage

//--- core/spicb_client.sv
// Contract
// - Dummy-first buffered client sends one dummy byte before user data.
// - Dummy-first setting: every data write goes into the transmit buffer.
// - The dummy byte is whatever the shift register holds.
// - On byte completion a pending buffer value moves into the shift register.
// - Write while buffer full and empty flag low is dropped unchanged.
// - Empty flag clears on buffer write, sets when buffer moves to shifter.
// - Receive-complete flag sets one cycle after empty flag rises.
// - Transfer-complete sets one cycle after receive-complete, once all sent.
// - Immediate-start: write with select high loads shifter next cycle.
// - Immediate-start: later writes go to buffer, flags identical.
// - Select, MOSI, SCK are inputs; MISO follows direction and select.
// - Select low: drive MISO on SCK pulses if direction is output.
// - Select high: deactivated, ignore data, tri-state MISO.
// - Select rising resets state and bit counter, aborting the transfer.
// - Mode field picks phase and polarity; shift and latch opposite edges.
// - Leading edge is first edge of an SCK cycle, trailing the last.
// - Level event mirrors SCK, lasting at least two clock periods.
// - One interrupt output; sources depend on normal or buffered operation.
// - Each source has its own enable bit; normal mode gates both its flags with enable bit 0.
// - Interrupt holds while flag and enable are set, until flag cleared.
// - Modes 0..3: leading rising/falling, sample or setup; rising idles low.
// - Buffer enable gives two receive entries and one transmit buffer.
// - Bit order zero sends MSB first, one sends LSB first.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module spicb_client
   import spicb_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sck_pin,
   input wire logic ss_n_pin,
   input wire logic mosi_pin,
   input wire logic miso_dir_out,
   output logic miso_o,
   output logic miso_oe,
   output logic spi_irq,
   output logic sck_event
);

   // ***************************************************************
   // State and derived controls
   // ***************************************************************
   spicb_regs_t r;
   spicb_regs_t n;
   spicb_req_t req;
   logic [2:0] filt_next;
   logic buffered;
   logic wait_recv;
   logic lsb_first;
   logic cpol;
   logic cpha;
   logic sel_now;
   logic sck_rise;
   logic sck_fall;
   logic lead_edge;
   logic trail_edge;
   logic sample_edge;
   logic setup_edge;
   logic sel_rise;
   logic sel_fall;
   logic data_wr;
   logic data_rd;
   logic byte_done;
   logic [7:0] rx_byte;
   logic buf_write_ok;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Change accepted only once stages two and three agree; stage one feeds only stage two
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         assign filt_next[gi] = (r.s2[gi] == r.s3[gi]) ? r.s3[gi] : r.filt[gi];
      end
   endgenerate

   // Control decode
   assign buffered = r.ctrl_second_reg[CS_BUF_EN_BIT];
   assign wait_recv = r.ctrl_second_reg[CS_WAIT_RECV_BIT];
   assign lsb_first = r.ctrl_first_reg[CF_BIT_ORDER_BIT];
   assign cpol = r.ctrl_second_reg[CS_MODE_LSB + 1];
   assign cpha = r.ctrl_second_reg[CS_MODE_LSB];
   assign sel_now = r.ctrl_first_reg[CF_ENABLE_BIT] & ~r.filt[PIN_SEL];

   // Edge classification on the filtered clock
   assign sck_rise = ~r.filt[PIN_SCK] & filt_next[PIN_SCK];
   assign sck_fall = r.filt[PIN_SCK] & ~filt_next[PIN_SCK];
   assign lead_edge = cpol ? sck_fall : sck_rise;
   assign trail_edge = cpol ? sck_rise : sck_fall;
   assign sample_edge = cpha ? trail_edge : lead_edge;
   assign setup_edge = cpha ? lead_edge : trail_edge;
   assign sel_rise = ~r.filt[PIN_SEL] & filt_next[PIN_SEL];
   assign sel_fall = r.filt[PIN_SEL] & ~filt_next[PIN_SEL];

   assign data_wr = req.wr && (req.addr == OFF_DATA);
   assign data_rd = req.rd && (req.addr == OFF_DATA);
   assign byte_done = sel_now && sample_edge && (r.bitcnt == LAST_BIT);
   assign rx_byte = lsb_first ? {r.filt[PIN_MOSI], r.rx_sh[7:1]} :
                                {r.rx_sh[6:0], r.filt[PIN_MOSI]};
   assign buf_write_ok = r.irq_flag_reg[FL_EMPTY_BIT];

   // ***************************************************************
   // Next-state logic
   // ***************************************************************
   always_comb begin
      n = r;
      n.s1 = {mosi_pin, ss_n_pin, sck_pin};
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.filt = filt_next;
      n.done_d1 = 1'b0;
      n.done_d2 = r.done_d1;

      // Register writes; flags are write-one-to-clear, sets below win
      if (req.wr) begin
         case (req.addr)
            OFF_CTRL_FIRST: n.ctrl_first_reg = req.wdata;
            OFF_CTRL_SECOND: n.ctrl_second_reg = req.wdata;
            OFF_IRQ_ENABLE: n.irq_enable_reg = req.wdata;
            OFF_IRQ_FLAG: n.irq_flag_reg = r.irq_flag_reg & ~req.wdata;
            default: n.ctrl_first_reg = r.ctrl_first_reg;
         endcase
      end

      // Data writes: buffered path first, then normal path
      if (data_wr) begin
         if (buffered) begin
            if (wait_recv && r.filt[PIN_SEL] && !r.sh_user) begin
               n.tx_sh = req.wdata;
               n.sh_user = 1'b1;
            end else if (buf_write_ok) begin
               n.txbuf = req.wdata;
               n.txbuf_full = 1'b1;
               n.irq_flag_reg[FL_EMPTY_BIT] = 1'b0;
            end
            // Otherwise the byte is dropped and the buffer left alone
         end else if (r.bitcnt != 3'h0 || r.pend) begin
            n.irq_flag_reg[FL_XFER_BIT] = 1'b1; // write collision in normal mode
         end else begin
            n.tx_sh = req.wdata;
         end
      end

      // Reading data pops the receive queue
      if (data_rd && r.fcnt != 2'h0) begin
         n.fifo0 = r.fifo1;
         n.fcnt = r.fcnt - 2'h1;
      end

      // Shift engine; inactive while select is high
      case (r.st)
         SPICB_IDLE: begin
            n.bitcnt = 3'h0;
            n.pend = 1'b0;
            if (sel_now) begin
               n.st = SPICB_SHIFT;
            end
         end
         SPICB_SHIFT: begin
            // Edges count only while selected, so a late edge beside a deselect is dropped
            if (sample_edge && sel_now) begin
               n.rx_sh = rx_byte;
               n.bitcnt = r.bitcnt + 3'h1;
               n.pend = 1'b1;
            end
            if (setup_edge && r.pend && sel_now) begin
               // Shift only after a sample so the first bit stands before any edge
               n.tx_sh = lsb_first ? {1'b0, r.tx_sh[7:1]} : {r.tx_sh[6:0], 1'b0};
               n.pend = 1'b0;
            end
            if (byte_done) begin
               n.pend = 1'b0;
               n.done_d1 = 1'b1;
               // A write landing on this very edge still counts as pending
               n.txc_ok = !n.txbuf_full;
               if (n.txbuf_full) begin
                  n.tx_sh = n.txbuf;
                  n.txbuf_full = 1'b0;
                  n.sh_user = 1'b1;
                  n.irq_flag_reg[FL_EMPTY_BIT] = 1'b1;
               end else begin
                  n.sh_user = 1'b0; // next byte is whatever is left
               end
               // Queue the byte in the same edge that ends it
               if (n.fcnt == 2'h0) begin
                  n.fifo0 = rx_byte;
                  n.fcnt = 2'h1;
               end else if (n.fcnt == 2'h1) begin
                  n.fifo1 = rx_byte;
                  n.fcnt = FIFO_DEPTH;
               end else begin
                  n.irq_flag_reg[FL_OVERFLOW_BIT] = buffered;
               end
               if (!buffered) begin
                  n.irq_flag_reg[FL_RECV_BIT] = 1'b1; // normal mode byte flag
               end
            end
            if (!sel_now) begin
               // Abort: partial bytes are lost, counter realigns
               n.st = SPICB_IDLE;
               n.bitcnt = 3'h0;
               n.pend = 1'b0;
               n.rx_sh = BYTE_ZERO;
            end
         end
         default: begin
            n.st = SPICB_IDLE;
         end
      endcase

      // Buffered flag timing: receive then transfer complete
      if (buffered && r.done_d1) begin
         n.irq_flag_reg[FL_RECV_BIT] = 1'b1;
      end
      if (buffered && r.done_d2 && r.txc_ok) begin
         n.irq_flag_reg[FL_XFER_BIT] = 1'b1;
      end
      if (buffered && sel_fall) begin
         n.irq_flag_reg[FL_SELECT_BIT] = 1'b1;
      end

      // MISO drives only while selected and the pin points outward
      n.miso = lsb_first ? n.tx_sh[0] : n.tx_sh[7];
      n.miso_oe = sel_now && miso_dir_out && !sel_rise;

      // Single request line; buffered sources gated per bit, normal-mode sources by enable bit 0
      if (buffered) begin
         n.irq = |(r.irq_flag_reg[7:4] & r.irq_enable_reg[7:4]);
      end else begin
         n.irq = |r.irq_flag_reg[7:6] & r.irq_enable_reg[IE_NORMAL_BIT];
      end

      // Event follows SCK but each level is held two cycles minimum
      if (r.ev_cnt) begin
         n.ev_cnt = 1'b0;
      end else if (r.ev != r.filt[PIN_SCK]) begin
         n.ev = r.filt[PIN_SCK];
         n.ev_cnt = EV_HOLD_CNT;
      end

      // Read data stands in the cycle after the strobe only
      n.rdata = BYTE_ZERO;
      if (req.rd) begin
         case (req.addr)
            OFF_CTRL_FIRST: n.rdata = r.ctrl_first_reg;
            OFF_CTRL_SECOND: n.rdata = r.ctrl_second_reg;
            OFF_IRQ_ENABLE: n.rdata = r.irq_enable_reg;
            OFF_IRQ_FLAG: n.rdata = r.irq_flag_reg;
            OFF_DATA: n.rdata = r.fifo0;
            default: n.rdata = BYTE_ZERO;
         endcase
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
         r.s1 <= 3'h2;
         r.s2 <= 3'h2;
         r.s3 <= 3'h2;
         r.filt <= 3'h2;
         r.st <= SPICB_IDLE;
         r.ctrl_first_reg <= CTRL_RESET;
         r.ctrl_second_reg <= CTRL_RESET;
         r.irq_enable_reg <= IRQ_EN_RESET;
         r.irq_flag_reg <= FLAG_RESET;
      end else begin
         r <= n;
      end
   end

   assign reg_rdata = r.rdata;
   assign miso_o = r.miso;
   assign miso_oe = r.miso_oe;
   assign spi_irq = r.irq;
   assign sck_event = r.ev;

   // ***************************************************************
   // Checks
   // ***************************************************************
   recv_after_empty_a: assert property (
      @(posedge clock) disable iff (!nrst)
      buffered && $rose(r.irq_flag_reg[FL_EMPTY_BIT]) && !$past(data_wr)
      |-> ##1 r.irq_flag_reg[FL_RECV_BIT])
      else $error("receive flag not set one cycle after empty flag");

   xfer_after_recv_a: assert property (
      @(posedge clock) disable iff (!nrst)
      buffered && r.done_d1 && r.txc_ok |-> ##1 r.irq_flag_reg[FL_RECV_BIT]
      ##1 r.irq_flag_reg[FL_XFER_BIT])
      else $error("transfer flag not one cycle after receive flag");

   full_write_drop_a: assert property (
      @(posedge clock) disable iff (!nrst)
      data_wr && buffered && r.txbuf_full && !buf_write_ok
      |=> r.txbuf == $past(r.txbuf))
      else $error("write into full buffer altered it");

   empty_clear_a: assert property (
      @(posedge clock) disable iff (!nrst)
      data_wr && buffered && buf_write_ok && !(wait_recv && r.filt[PIN_SEL] && !r.sh_user)
      && !byte_done |=> !r.irq_flag_reg[FL_EMPTY_BIT] && r.txbuf_full)
      else $error("buffer write did not clear empty flag");

   immediate_load_a: assert property (
      @(posedge clock) disable iff (!nrst)
      data_wr && buffered && wait_recv && r.filt[PIN_SEL] && !r.sh_user
      |=> r.tx_sh == $past(req.wdata))
      else $error("immediate write not in shift register");

   dummy_keep_a: assert property (
      @(posedge clock) disable iff (!nrst)
      data_wr && buffered && !wait_recv && r.st == SPICB_IDLE
      |=> r.tx_sh == $past(r.tx_sh))
      else $error("dummy-first write reached shift register");

   miso_tristate_a: assert property (
      @(posedge clock) disable iff (!nrst)
      r.filt[PIN_SEL] |=> !miso_oe)
      else $error("MISO driven while deselected");

   abort_reset_a: assert property (
      @(posedge clock) disable iff (!nrst)
      r.st == SPICB_SHIFT && r.filt[PIN_SEL] |=> r.bitcnt == 3'h0 && r.st == SPICB_IDLE)
      else $error("deselect did not reset bit counter");

   irq_hold_a: assert property (
      @(posedge clock) disable iff (!nrst)
      buffered && $stable(r.ctrl_second_reg)
      && |(r.irq_flag_reg[7:4] & r.irq_enable_reg[7:4]) |=> spi_irq)
      else $error("interrupt not asserted for enabled flag");

   event_hold_a: assert property (
      @(posedge clock) disable iff (!nrst)
      $changed(sck_event) |=> $stable(sck_event))
      else $error("event level shorter than two cycles");

endmodule

`default_nettype wire

//--- tb/spicb_client_tb.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module spicb_client_tb
   import spicb_pkg::*;
;
   logic clock;
   logic nrst;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic sck_pin;
   logic ss_n_pin;
   logic mosi_pin;
   logic miso_dir_out;
   logic miso_o;
   logic miso_oe;
   logic spi_irq;
   logic sck_event;
   int failures = 0;
   int cmp_count = 0;
   int ev_run = 0;
   int ev_tog = 0;
   logic ev_last = 1'b0;
   logic lsb;
   logic [1:0] mm;
   logic [7:0] d;
   logic [7:0] got;
   logic [7:0] exp_q[$];
   logic [7:0] rxq[$];

   spicb_client dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_pin(sck_pin),
      .ss_n_pin(ss_n_pin), .mosi_pin(mosi_pin), .miso_dir_out(miso_dir_out),
      .miso_o(miso_o), .miso_oe(miso_oe), .spi_irq(spi_irq), .sck_event(sck_event));

   spicb_host host (.sck_pin(sck_pin), .ss_n_pin(ss_n_pin), .mosi_pin(mosi_pin),
      .miso_o(miso_o), .miso_oe(miso_oe));

   always #5 clock = ~clock;

   // ***************************************************************
   // Register port tasks
   // ***************************************************************
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic chk_rd(input logic [2:0] a, input logic [7:0] mask, input logic [7:0] e);
      rd(a, d);
      `CHK(d & mask, e)
   endtask

   // Expected MISO bytes come from the queue; received bytes feed the rx model
   // Expected values are popped once, before the compare, so a miss cannot skew the queue
   task automatic do_byte(input int nbits);
      logic [7:0] tx;
      logic [7:0] e;
      tx = 8'($urandom);
      host.shift(tx, lsb, nbits, got);
      if (nbits == 8) begin
         rxq.push_back(tx);
      end
      if (nbits == 8 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         `CHK(got, e)
      end
      repeat (10) @(posedge clock);
   endtask

   task automatic pop_rx;
      logic [7:0] e;
      rd(OFF_DATA, d);
      e = rxq.pop_front();
      `CHK(d, e)
   endtask

   task automatic cfg(input logic [1:0] m, input logic order, input logic wait_sel);
      lsb = order;
      wr(OFF_CTRL_FIRST, {1'b0, order, 5'h00, 1'b1});
      wr(OFF_CTRL_SECOND, {1'b1, wait_sel, 4'h0, m});
      host.set_mode(m);
   endtask

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Each level of the event must last two clocks or more; read away from the launching edge
   always @(negedge clock) begin
      if (nrst === 1'b1 && sck_event !== ev_last) begin
         `CHK(ev_run >= 2, 1'b1)
         ev_run = 0;
         ev_tog++;
      end
      ev_last = sck_event;
      ev_run++;
   end

   // Whole run needs some 19 us; this bound only trips on a hang
   initial begin
      #500000;
      failures++;
      print_verdict;
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      miso_dir_out = 1'b1;
      lsb = 1'b0;
      void'($urandom(76496));
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      repeat (5) @(posedge clock);
      chk_rd(OFF_IRQ_ENABLE, 8'hFF, IRQ_EN_RESET);
      chk_rd(OFF_IRQ_FLAG, 8'hFF, FLAG_RESET);
      chk_rd(3'h5, 8'hFF, BYTE_ZERO);
      `CHK(spi_irq, 1'b0)
      // Dummy-first: the reset shift register is sent before user data
      cfg(2'h0, 1'b0, 1'b0);
      wr(OFF_DATA, 8'h43);
      chk_rd(OFF_IRQ_FLAG, 8'h20, 8'h00);
      exp_q = '{BYTE_ZERO, 8'h43, 8'h44};
      host.select(1'b0);
      `CHK(miso_oe, 1'b1)
      do_byte(8);
      pop_rx;
      chk_rd(OFF_IRQ_FLAG, 8'hE0, 8'hA0);
      wr(OFF_DATA, 8'h44);
      wr(OFF_DATA, 8'h45);
      chk_rd(OFF_IRQ_FLAG, 8'h20, 8'h00);
      do_byte(8);
      pop_rx;
      chk_rd(OFF_IRQ_FLAG, 8'h40, 8'h00);
      do_byte(8);
      pop_rx;
      chk_rd(OFF_IRQ_FLAG, 8'hE0, 8'hE0);
      miso_dir_out <= 1'b0;
      repeat (3) @(posedge clock);
      `CHK(miso_oe, 1'b0)
      miso_dir_out <= 1'b1;
      host.select(1'b1);
      `CHK(miso_oe, 1'b0)
      // Immediate start in every mode, bit order flipping
      for (int m = 0; m < 4; m++) begin
         mm = 2'(m);
         cfg(mm, ^mm, 1'b1);
         d = 8'($urandom);
         exp_q.push_back(d);
         wr(OFF_DATA, d);
         d = 8'($urandom);
         exp_q.push_back(d);
         wr(OFF_DATA, d);
         host.select(1'b0);
         do_byte(8);
         do_byte(8);
         host.select(1'b1);
         pop_rx;
         pop_rx;
      end
      // Select rising mid-byte drops the partial byte
      wr(OFF_IRQ_FLAG, 8'hFF);
      host.select(1'b0);
      do_byte(4);
      host.select(1'b1);
      chk_rd(OFF_IRQ_FLAG, 8'h80, 8'h00);
      wr(OFF_IRQ_ENABLE, 8'h80);
      host.select(1'b0);
      do_byte(8);
      host.select(1'b1);
      pop_rx;
      `CHK(spi_irq, 1'b1)
      wr(OFF_IRQ_ENABLE, 8'h00);
      repeat (3) @(posedge clock);
      `CHK(spi_irq, 1'b0)
      wr(OFF_IRQ_ENABLE, 8'h80);
      repeat (3) @(posedge clock);
      `CHK(spi_irq, 1'b1)
      wr(OFF_IRQ_FLAG, 8'h80);
      repeat (3) @(posedge clock);
      `CHK(spi_irq, 1'b0)
      // Normal mode: direct load, byte flag, collision on a write mid-byte
      wr(OFF_CTRL_SECOND, 8'h00);
      wr(OFF_IRQ_FLAG, 8'hFF);
      wr(OFF_IRQ_ENABLE, 8'h01);
      host.set_mode(2'h0);
      d = 8'($urandom);
      exp_q.push_back(d);
      wr(OFF_DATA, d);
      host.select(1'b0);
      do_byte(8);
      pop_rx;
      `CHK(spi_irq, 1'b1)
      do_byte(4);
      wr(OFF_DATA, 8'h5A);
      chk_rd(OFF_IRQ_FLAG, 8'hC0, 8'hC0);
      host.select(1'b1);
      `CHK(ev_tog > 0, 1'b1)
      print_verdict;
   end
endmodule

`default_nettype wire

//--- tb/spicb_host.sv
`timescale 1ns/1ns
`default_nettype none

// ***************************************************************
// Behavioural SPI host on the far side of the client
// ***************************************************************
module spicb_host (
   output logic sck_pin,
   output logic ss_n_pin,
   output logic mosi_pin,
   input wire logic miso_o,
   input wire logic miso_oe
);
   logic cpol = 1'b0;
   logic cpha = 1'b0;
   logic miso_line;

   // Pins start deselected with the clock at its mode 0 idle level
   initial begin
      sck_pin = 1'b0;
      ss_n_pin = 1'b1;
      mosi_pin = 1'b0;
   end

   // An undriven MISO shows the inverse of the last bit, never a stale bit
   assign miso_line = miso_oe ? miso_o : ~miso_o;

   // Idle level only changes while deselected
   task automatic set_mode(input logic [1:0] m);
      cpol = m[1];
      cpha = m[0];
      sck_pin = m[1];
   endtask

   // Select frames each transfer; the gap covers the client's input sync
   task automatic select(input logic lvl);
      ss_n_pin = lvl;
      #100;
      if (lvl) begin
         mosi_pin = ~mosi_pin;
      end
   endtask

   // Half periods of 62 and 63 ns give the 125 ns link clock
   task automatic shift(input logic [7:0] tx, input logic lsb, input int nbits,
                        output logic [7:0] rx);
      int b;
      rx = 8'h00;
      for (int i = 0; i < nbits; i++) begin
         b = lsb ? i : 7 - i;
         if (cpha) begin
            sck_pin = ~cpol;
         end
         mosi_pin = tx[b];
         #62;
         sck_pin = cpha ? cpol : ~cpol;
         rx[b] = miso_line;
         #63;
         if (!cpha) begin
            sck_pin = cpol;
         end
      end
   endtask
endmodule

`default_nettype wire
